// ===== bench/sst_save_area.sv
// Model of the save area in memory: base address and header words.
// Assumes the bench copies the image into the block's register images.
`timescale 1ns/10ps
module sst_save_area;
  logic [63:0] base_addr;
  logic [63:0] hdr_state;
  logic [63:0] hdr_comp;

  task automatic set_area(input logic [63:0] b, input logic [63:0] s, input logic [63:0] c);
    base_addr = b;
    hdr_state = s;
    hdr_comp = c;
  endtask : set_area
endmodule : sst_save_area

// ===== bench/sst_top_monitor.sv
// Concurrent checks on the register bus of the state-save tracking block.
// Assumes the AXI4-Lite port list of sst_top; bound at the foot of this file.
`timescale 1ns/10ps
module sst_top_monitor
  import sst_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // Bus handshakes
  // ****************************************
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  r_latency_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  b_latency_a: assert property (wr_taken |=> ##1 s_axi_bvalid)
    else $error("write response late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  aw_block_a: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write ready still high after take");
  rd_unmapped_a: assert property (rd_taken ##0 s_axi_araddr[7:2] > SST_OFS_REC[7:2]
    |=> s_axi_rresp == SST_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  wr_unmapped_a: assert property (wr_taken ##0 s_axi_awaddr[7:2] > SST_OFS_REC[7:2]
    |=> ##1 s_axi_bresp == SST_RESP_SLVERR)
    else $error("unmapped write not refused");
  cmd_read_a: assert property (rd_taken ##0 s_axi_araddr[7:2] == SST_OFS_CMD[7:2]
    |=> s_axi_rdata == 32'h0)
    else $error("command word reads nonzero");
endmodule : sst_top_monitor

bind sst_top sst_top_monitor i_mon (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);

// ===== bench/test_state_save_tracking.sv
// Self-checking bench: register tasks over AXI4-Lite, then restore and save sequences.
// Assumes sst_top, its package, the save-area model and the bound monitor.
`timescale 1ns/10ps
module test_state_save_tracking
  import sst_pkg::*;
;
  logic clock, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [63:0] comp_touch;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] ofs_t[3] = '{SST_OFS_ADDR_LO, SST_OFS_MODE, SST_OFS_MODE};
  logic [31:0] off_v[3] = '{32'h0000_1040, 32'h0000_000a, 32'h0000_000d};
  logic [31:0] on_v[3] = '{32'h0000_1000, 32'h0000_000e, 32'h0000_000e};

  sst_top i_sst_top (.clock, .rst_b, .comp_touch, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sst_save_area i_sst_save_area ();

  always #4 clock = ~clock;

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic close_out();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 40) begin
      bad_count++;
      close_out();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 40) begin
      bad_count++;
      close_out();
    end
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rv, exp);
  endtask : rchk

  task automatic save_chk(input logic [31:0] status, input logic [31:0] stored);
    wr(SST_OFS_CMD, 32'h2);
    rchk(SST_OFS_STATUS, status);
    rchk(SST_OFS_STORED_LO, stored);
  endtask : save_chk

  task automatic touch(input logic [63:0] v);
    @(posedge clock);
    comp_touch <= v;
    @(posedge clock);
    comp_touch <= 64'h0;
  endtask : touch

  task automatic load(input logic [63:0] b, input logic [63:0] s, input logic [63:0] c);
    i_sst_save_area.set_area(b, s, c);
    wr(SST_OFS_ADDR_LO, i_sst_save_area.base_addr[31:0]);
    wr(SST_OFS_HSV_LO, i_sst_save_area.hdr_state[31:0]);
    wr(SST_OFS_HSV_HI, i_sst_save_area.hdr_state[63:32]);
    wr(SST_OFS_HCV_LO, i_sst_save_area.hdr_comp[31:0]);
    wr(SST_OFS_HCV_HI, i_sst_save_area.hdr_comp[63:32]);
  endtask : load

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    comp_touch = 64'h0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    rchk(SST_OFS_FER_LO, 32'h3);
    rchk(SST_OFS_INUSE_HI, 32'h8000_0000);
    rchk(SST_OFS_MOD_LO, 32'hffff_ffff);
    rchk(SST_OFS_REC, 32'h0);
    rd(8'h7c);
    chk(32'(rs), 32'(SST_RESP_SLVERR));
    wr(8'h7c, 32'h1);
    chk(32'(rs), 32'(SST_RESP_SLVERR));
    rchk(SST_OFS_CMD, 32'h0);
    // Faults in priority order
    wr(SST_OFS_CR0, 32'h8);
    wr(SST_OFS_MODE, 32'h0);
    load(64'h1008, 64'hfb, 64'h11);
    wr(SST_OFS_FER_LO, 32'h7);
    wr(SST_OFS_MASK_LO, 32'h6);
    save_chk(32'h21, 32'h0);
    wr(SST_OFS_MODE, 32'h8);
    save_chk(32'h22, 32'h0);
    wr(SST_OFS_CR0, 32'h0);
    save_chk(32'h24, 32'h0);
    rchk(SST_OFS_HSV_LO, 32'hfb);
    // Init optimization
    touch(64'h5);
    load(64'h1000, 64'hfb, 64'h11);
    save_chk(32'h30, 32'h4);
    rchk(SST_OFS_HSV_LO, 32'hfd);
    rchk(SST_OFS_HCV_LO, 32'h11);
    wr(SST_OFS_MASK_LO, 32'h4);
    save_chk(32'h30, 32'h4);
    wr(SST_OFS_MASK_LO, 32'h1);
    save_chk(32'h20, 32'h1);
    // Restore and its tracking
    wr(SST_OFS_MODE, 32'he);
    wr(SST_OFS_FER_LO, 32'hf);
    wr(SST_OFS_FER_HI, 32'h8000_0000);
    wr(SST_OFS_MASK_LO, 32'h3);
    wr(SST_OFS_MASK_HI, 32'h8000_0000);
    load(64'h1000, 64'h2, 64'h0);
    wr(SST_OFS_CMD, 32'h1);
    rchk(SST_OFS_INUSE_LO, 32'h6);
    rchk(SST_OFS_INUSE_HI, 32'h8000_0000);
    rchk(SST_OFS_MOD_LO, 32'hffff_fffc);
    rchk(SST_OFS_MOD_HI, 32'hffff_ffff);
    rchk(SST_OFS_REC, 32'he);
    // Modified optimization
    wr(SST_OFS_MASK_LO, 32'h7);
    save_chk(32'h38, 32'h4);
    rchk(SST_OFS_HSV_LO, 32'h6);
    rchk(SST_OFS_HSV_HI, 32'h8000_0000);
    rchk(SST_OFS_STORED_HI, 32'h0);
    touch(64'h2);
    save_chk(32'h38, 32'h6);
    for (int i = 0; i < 3; i++) begin
      wr(ofs_t[i], off_v[i]);
      save_chk(32'h30, 32'h6);
      wr(ofs_t[i], on_v[i]);
    end
    save_chk(32'h38, 32'h6);
    wr(SST_OFS_HCV_HI, 32'h8000_0000);
    wr(SST_OFS_CMD, 32'h1);
    save_chk(32'h30, 32'h6);
    // Empty request on restore
    wr(SST_OFS_MASK_LO, 32'h0);
    wr(SST_OFS_MASK_HI, 32'h0);
    wr(SST_OFS_CMD, 32'h1);
    rchk(SST_OFS_MOD_LO, 32'hffff_ffff);
    rchk(SST_OFS_INUSE_LO, 32'h6);
    close_out();
  end
endmodule : test_state_save_tracking

// ===== hdl/sst_pkg.sv
// Constants for the state-save tracking block: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus and 64 state components.
package sst_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int SST_ADDR_W = 8;
  localparam int SST_DATA_W = 32;
  localparam int SST_NCOMP = 64;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] SST_OFS_CR0 = 8'h00;
  localparam logic [7:0] SST_OFS_MODE = 8'h04;
  localparam logic [7:0] SST_OFS_FER_LO = 8'h08;
  localparam logic [7:0] SST_OFS_FER_HI = 8'h0c;
  localparam logic [7:0] SST_OFS_MASK_LO = 8'h10;
  localparam logic [7:0] SST_OFS_MASK_HI = 8'h14;
  localparam logic [7:0] SST_OFS_ADDR_LO = 8'h18;
  localparam logic [7:0] SST_OFS_ADDR_HI = 8'h1c;
  localparam logic [7:0] SST_OFS_HSV_LO = 8'h20;
  localparam logic [7:0] SST_OFS_HSV_HI = 8'h24;
  localparam logic [7:0] SST_OFS_HCV_LO = 8'h28;
  localparam logic [7:0] SST_OFS_HCV_HI = 8'h2c;
  localparam logic [7:0] SST_OFS_CMD = 8'h30;
  localparam logic [7:0] SST_OFS_STATUS = 8'h34;
  localparam logic [7:0] SST_OFS_INUSE_LO = 8'h38;
  localparam logic [7:0] SST_OFS_INUSE_HI = 8'h3c;
  localparam logic [7:0] SST_OFS_MOD_LO = 8'h40;
  localparam logic [7:0] SST_OFS_MOD_HI = 8'h44;
  localparam logic [7:0] SST_OFS_STORED_LO = 8'h48;
  localparam logic [7:0] SST_OFS_STORED_HI = 8'h4c;
  localparam logic [7:0] SST_OFS_REC = 8'h50;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SST_TASK_SWITCHED_FLAG_BIT = 3;
  localparam int SST_MODE_CPL_LSB = 0;
  localparam int SST_MODE_GUEST_BIT = 2;
  localparam int SST_MODE_OSXE_BIT = 3;
  localparam int SST_CMD_RESTORE_BIT = 0;
  localparam int SST_CMD_SAVE_BIT = 1;
  localparam int SST_ST_UD_BIT = 0;
  localparam int SST_ST_NM_BIT = 1;
  localparam int SST_ST_GP_BIT = 2;
  localparam int SST_ST_MODOPT_BIT = 3;
  localparam int SST_ST_VCS_BIT = 4;
  localparam int SST_ST_DONE_BIT = 5;
  localparam int SST_REC_VALID_BIT = 3;
  localparam int SST_HCV_FORM_BIT = 63;
  localparam int SST_ALIGN_BITS = 6;
  localparam int SST_VEC_COMP = 1;
  localparam int SST_AVX_COMP = 2;
  localparam int SST_LAST_COMP = 62;

  // ****************************************
  // Reset values and tracking capability
  // ****************************************
  localparam logic [63:0] SST_INIT_TRACK = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] SST_MOD_TRACK = 64'h7fff_ffff_ffff_ffff;
  localparam logic [63:0] SST_FER_RST = 64'h0000_0000_0000_0003;
  localparam logic [1:0] SST_RESP_OKAY = 2'h0;
  localparam logic [1:0] SST_RESP_SLVERR = 2'h2;

endpackage : sst_pkg

// ===== hdl/sst_top.sv
// State-save tracking: in-use and modified bitmaps, restore record, optimized save.
// Assumes a synchronous AXI4-Lite master on the 125 MHz clock; comp_touch pulses
// come from execution units whenever they change a state component.
//
// How it works
// - Unrequested components keep their in-use bit on restore
// - Requested, header zero: in-use bit may clear
// - Requested, header one: in-use bit set
// - Untracked components hold in-use bit at one
// - Unrequested components marked modified on restore
// - Requested may clear modified; untracked stays one
// - Restore records privilege, guest, address, compaction
// - Standard form records zero compaction value
// - Save faults invalid opcode without OS enable
// - Save faults device unavailable when task-switched
// - Save faults general protection when misaligned
// - Requested bitmap is enable AND instruction mask
// - Save rewrites header vector, unrequested bits kept
// - Requested header bits take the in-use bit
// - Header bit one ignores vector control status
// - Save leaves compaction vector untouched
// - Components 0-1 legacy, 2-62 standard extended
// - Init optimization skips components not in use
// - Modified optimization only on matching zero record
// - Modified optimization skips unmodified components
// - Vector control stored when bit 1 or 2
// - Vector control never skipped by optimizations
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module sst_top
  import sst_pkg::*;
(
  input wire logic clock, // 125 MHz clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [63:0] comp_touch, // Per-component change pulses
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  // ****************************************
  // Declarations
  // ****************************************
  logic awready_r;
  logic wready_r;
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic aw_held_nxt;
  logic w_held_nxt;
  logic rvalid_nxt;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;

  logic [31:0] cr0_r;
  logic [1:0] cpl_r;
  logic guest_r;
  logic osxe_r;
  logic [63:0] fer_r;
  logic [63:0] mask_r;
  logic [63:0] area_r;
  logic [63:0] hsv_r;
  logic [63:0] hcv_r;
  logic restore_go_r;
  logic save_go_r;
  logic [5:0] status_r;
  logic [63:0] stored_r;
  logic [63:0] in_use_bitmap_r;
  logic [63:0] modified_bitmap_r;
  logic [1:0] rec_cpl_r;
  logic rec_guest_r;
  logic [63:0] rec_addr_r;
  logic [63:0] rec_comp_r;
  logic rec_valid_r;

  logic [63:0] requested_feature_bitmap;
  logic fault_ud;
  logic fault_nm;
  logic fault_gp;
  logic mod_opt;
  logic [63:0] hsv_nxt;
  logic [63:0] store_nxt;
  logic vcs_store;

  // Byte-lane merge of a 32-bit register half
  function automatic logic [31:0] sst_merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : sst_merge

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign aw_take = s_axi_awvalid & awready_r;
  assign w_take = s_axi_wvalid & wready_r;
  assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  assign aw_held_nxt = (aw_held_r & ~wr_fire) | aw_take;
  assign w_held_nxt = (w_held_r & ~wr_fire) | w_take;

  always_comb begin
    case (awaddr_r)
      SST_OFS_CR0, SST_OFS_MODE, SST_OFS_FER_LO, SST_OFS_FER_HI,
      SST_OFS_MASK_LO, SST_OFS_MASK_HI, SST_OFS_ADDR_LO, SST_OFS_ADDR_HI,
      SST_OFS_HSV_LO, SST_OFS_HSV_HI, SST_OFS_HCV_LO, SST_OFS_HCV_HI,
      SST_OFS_CMD: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awready_r <= ~aw_held_nxt;
      wready_r <= ~w_held_nxt;
      if (aw_take) begin
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bvalid_r <= 1'b0;
      bresp_r <= SST_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? SST_RESP_OKAY : SST_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign ar_take = s_axi_arvalid & arready_r;
  assign rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);

  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'h0})
      SST_OFS_CR0: rd_word = cr0_r;
      SST_OFS_MODE: rd_word = {28'h0000000, osxe_r, guest_r, cpl_r};
      SST_OFS_FER_LO: rd_word = fer_r[31:0];
      SST_OFS_FER_HI: rd_word = fer_r[63:32];
      SST_OFS_MASK_LO: rd_word = mask_r[31:0];
      SST_OFS_MASK_HI: rd_word = mask_r[63:32];
      SST_OFS_ADDR_LO: rd_word = area_r[31:0];
      SST_OFS_ADDR_HI: rd_word = area_r[63:32];
      SST_OFS_HSV_LO: rd_word = hsv_r[31:0];
      SST_OFS_HSV_HI: rd_word = hsv_r[63:32];
      SST_OFS_HCV_LO: rd_word = hcv_r[31:0];
      SST_OFS_HCV_HI: rd_word = hcv_r[63:32];
      SST_OFS_CMD: rd_word = 32'h0000_0000;
      SST_OFS_STATUS: rd_word = {26'h0, status_r};
      SST_OFS_INUSE_LO: rd_word = in_use_bitmap_r[31:0];
      SST_OFS_INUSE_HI: rd_word = in_use_bitmap_r[63:32];
      SST_OFS_MOD_LO: rd_word = modified_bitmap_r[31:0];
      SST_OFS_MOD_HI: rd_word = modified_bitmap_r[63:32];
      SST_OFS_STORED_LO: rd_word = stored_r[31:0];
      SST_OFS_STORED_HI: rd_word = stored_r[63:32];
      SST_OFS_REC: rd_word = {28'h0000000, rec_valid_r, rec_guest_r, rec_cpl_r};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= SST_RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? SST_RESP_OKAY : SST_RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cr0_r <= 32'h0000_0000;
      cpl_r <= 2'h0;
      guest_r <= 1'b0;
      osxe_r <= 1'b0;
      fer_r <= SST_FER_RST;
      mask_r <= 64'h0000_0000_0000_0000;
      area_r <= 64'h0000_0000_0000_0000;
      hcv_r <= 64'h0000_0000_0000_0000;
    end else if (wr_fire) begin
      case (awaddr_r)
        SST_OFS_CR0: cr0_r <= sst_merge(cr0_r, wdata_r, wstrb_r);
        SST_OFS_MODE: begin
          if (wstrb_r[0]) begin
            cpl_r <= wdata_r[SST_MODE_CPL_LSB +: 2];
            guest_r <= wdata_r[SST_MODE_GUEST_BIT];
            osxe_r <= wdata_r[SST_MODE_OSXE_BIT];
          end
        end
        SST_OFS_FER_LO: fer_r[31:0] <= sst_merge(fer_r[31:0], wdata_r, wstrb_r);
        SST_OFS_FER_HI: fer_r[63:32] <= sst_merge(fer_r[63:32], wdata_r, wstrb_r);
        SST_OFS_MASK_LO: mask_r[31:0] <= sst_merge(mask_r[31:0], wdata_r, wstrb_r);
        SST_OFS_MASK_HI: mask_r[63:32] <= sst_merge(mask_r[63:32], wdata_r, wstrb_r);
        SST_OFS_ADDR_LO: area_r[31:0] <= sst_merge(area_r[31:0], wdata_r, wstrb_r);
        SST_OFS_ADDR_HI: area_r[63:32] <= sst_merge(area_r[63:32], wdata_r, wstrb_r);
        SST_OFS_HCV_LO: hcv_r[31:0] <= sst_merge(hcv_r[31:0], wdata_r, wstrb_r);
        SST_OFS_HCV_HI: hcv_r[63:32] <= sst_merge(hcv_r[63:32], wdata_r, wstrb_r);
        default: begin
        end
      endcase
    end
  end

  // Command pulses, executed the cycle after the write lands
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      restore_go_r <= 1'b0;
      save_go_r <= 1'b0;
    end else begin
      restore_go_r <= wr_fire & (awaddr_r == SST_OFS_CMD) & wstrb_r[0] &
                      wdata_r[SST_CMD_RESTORE_BIT];
      save_go_r <= wr_fire & (awaddr_r == SST_OFS_CMD) & wstrb_r[0] &
                   wdata_r[SST_CMD_SAVE_BIT] & ~wdata_r[SST_CMD_RESTORE_BIT];
    end
  end

  // ****************************************
  // Optimized save decision
  // ****************************************
  assign requested_feature_bitmap = fer_r & mask_r;
  assign fault_ud = ~osxe_r;
  assign fault_nm = ~fault_ud & cr0_r[SST_TASK_SWITCHED_FLAG_BIT];
  assign fault_gp = ~fault_ud & ~fault_nm & (area_r[SST_ALIGN_BITS-1:0] != 6'h00);
  assign mod_opt = rec_valid_r & (rec_cpl_r == cpl_r) & (rec_guest_r == guest_r) &
                   (rec_addr_r == area_r) & (rec_comp_r == 64'h0000_0000_0000_0000);

  // Header bit 1 follows in-use alone, not the vector control value
  assign hsv_nxt = (hsv_r & ~requested_feature_bitmap) |
                   (requested_feature_bitmap & in_use_bitmap_r);

  // Components 0 and 1 land in the legacy region, 2..62 in the standard extended one
  always_comb begin
    store_nxt = requested_feature_bitmap & in_use_bitmap_r;
    if (mod_opt) begin
      store_nxt = store_nxt & modified_bitmap_r;
    end
    store_nxt[SST_NCOMP-1] = 1'b0;
  end

  assign vcs_store = requested_feature_bitmap[SST_VEC_COMP] |
                     requested_feature_bitmap[SST_AVX_COMP];

  // Header state vector; compaction vector is never written here
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hsv_r <= 64'h0000_0000_0000_0000;
    end else if (save_go_r & ~fault_ud & ~fault_nm & ~fault_gp) begin
      hsv_r <= hsv_nxt;
    end else if (wr_fire & (awaddr_r == SST_OFS_HSV_LO)) begin
      hsv_r[31:0] <= sst_merge(hsv_r[31:0], wdata_r, wstrb_r);
    end else if (wr_fire & (awaddr_r == SST_OFS_HSV_HI)) begin
      hsv_r[63:32] <= sst_merge(hsv_r[63:32], wdata_r, wstrb_r);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      status_r <= 6'h00;
      stored_r <= 64'h0000_0000_0000_0000;
    end else if (save_go_r) begin
      status_r <= 6'h00;
      status_r[SST_ST_UD_BIT] <= fault_ud;
      status_r[SST_ST_NM_BIT] <= fault_nm;
      status_r[SST_ST_GP_BIT] <= fault_gp;
      status_r[SST_ST_DONE_BIT] <= 1'b1;
      if (fault_ud | fault_nm | fault_gp) begin
        stored_r <= 64'h0000_0000_0000_0000;
      end else begin
        stored_r <= store_nxt;
        status_r[SST_ST_MODOPT_BIT] <= mod_opt;
        status_r[SST_ST_VCS_BIT] <= vcs_store;
      end
    end else if (restore_go_r) begin
      status_r <= 6'h00;
      status_r[SST_ST_DONE_BIT] <= 1'b1;
    end
  end

  // ****************************************
  // Restore record
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rec_valid_r <= 1'b0;
      rec_cpl_r <= 2'h0;
      rec_guest_r <= 1'b0;
      rec_addr_r <= 64'h0000_0000_0000_0000;
      rec_comp_r <= 64'h0000_0000_0000_0000;
    end else if (restore_go_r) begin
      rec_valid_r <= 1'b1;
      rec_cpl_r <= cpl_r;
      rec_guest_r <= guest_r;
      rec_addr_r <= area_r;
      rec_comp_r <= hcv_r[SST_HCV_FORM_BIT] ? hcv_r : 64'h0000_0000_0000_0000;
    end
  end

  // ****************************************
  // Per-component tracking; a change pulse wins over a restore
  // ****************************************
  for (genvar i = 0; i < SST_NCOMP; i++) begin : g_track
    always_ff @(posedge clock) begin
      if (!rst_b) begin
        in_use_bitmap_r[i] <= ~SST_INIT_TRACK[i];
      end else if (!SST_INIT_TRACK[i]) begin
        in_use_bitmap_r[i] <= 1'b1;
      end else if (comp_touch[i]) begin
        in_use_bitmap_r[i] <= 1'b1;
      end else if (restore_go_r & requested_feature_bitmap[i]) begin
        in_use_bitmap_r[i] <= hsv_r[i];
      end
    end

    always_ff @(posedge clock) begin
      if (!rst_b) begin
        modified_bitmap_r[i] <= 1'b1;
      end else if (!SST_MOD_TRACK[i] | comp_touch[i]) begin
        modified_bitmap_r[i] <= 1'b1;
      end else if (restore_go_r) begin
        modified_bitmap_r[i] <= ~requested_feature_bitmap[i];
      end
    end
  end

endmodule : sst_top
